// file: rtl/crm_core_regs.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "crm_regs.svh"


module crm_core_regs #(
    parameter logic [15:0] PROG_BASE = `CRM_PROG_BASE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire crm_pkg::crm_alu_req_t aluReq,
    input wire crm_pkg::crm_load_t loadReq,
    input wire logic countUp,
    input wire logic [15:0] memAddr,
    input wire logic irqReq,
    input wire logic [1:0] irqLevel,
    output crm_pkg::crm_regs_t regsOut,
    output logic [15:0] gprBase,
    output logic irqAccept,
    output logic areaIo,
    output logic areaData,
    output logic areaProg
);

    logic [15:0] progCnt_q;
    logic [15:0] accum_q;
    logic [15:0] accum_d;
    logic [15:0] tempAcc_q;
    logic [15:0] indexReg_q;
    logic [15:0] extraPtr_q;
    logic [15:0] stackPtr_q;
    logic [15:0] status_q;
    logic [15:0] statusAlu;
    logic [15:0] ddRdata_q;
    logic rdGpr_q;
    logic [15:0] gprBase_q;
    logic irqAccept_q;
    logic areaIo_q;
    logic areaData_q;
    logic areaProg_q;
    logic [`CRM_MEM_DW-1:0] memRdata;
    logic [3:0] bank;
    logic gprHit;
    logic aluTake;
    logic [15:0] opA;
    logic [15:0] opB;
    logic [16:0] res17;
    logic [4:0] half5;
    logic carryIn;
    logic signA;
    logic signB;
    logic signR;

    // A bus write or a datapath load to the given index this cycle.
    function automatic logic busWrHit(input logic [3:0] idx);
        busWrHit = regWr && (regAddr == idx);
    endfunction : busWrHit

    function automatic logic loadHit(input logic [3:0] idx);
        loadHit = loadReq.valid && (loadReq.sel == idx);
    endfunction : loadHit

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode; the bus outranks the datapath so software can
    // always repair state, at the cost of dropping a colliding update.
    assign bank = status_q[`CRM_BANK_MSB:`CRM_BANK_LSB];
    assign gprHit = regAddr[`CRM_IDX_GPR_BIT];
    assign aluTake = aluReq.valid && !busWrHit(`CRM_IDX_ACCUM) && !loadHit(`CRM_IDX_ACCUM);

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator arithmetic on the low byte or on the full word.
    always_comb begin
        opA = aluReq.wide ? accum_q : {8'h00, accum_q[7:0]};
        opB = aluReq.wide ? tempAcc_q : {8'h00, tempAcc_q[7:0]};
        carryIn = status_q[`CRM_FLAG_CARRY];
        res17 = '0;
        half5 = '0;
        statusAlu = status_q;
        unique case (aluReq.op)
            crm_pkg::OP_ADD, crm_pkg::OP_ADDC: begin
                if (aluReq.op == crm_pkg::OP_ADD) begin
                    carryIn = 1'b0;
                end
                res17 = {1'b0, opA} + {1'b0, opB} + {16'h0000, carryIn};
                half5 = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
            end
            crm_pkg::OP_SUB, crm_pkg::OP_SUBC: begin
                if (aluReq.op == crm_pkg::OP_SUB) begin
                    carryIn = 1'b0;
                end
                res17 = {1'b0, opA} - {1'b0, opB} - {16'h0000, carryIn};
                half5 = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
            end
            crm_pkg::OP_SHL: begin
                res17 = {1'b0, opA[14:0], carryIn};
            end
            crm_pkg::OP_SHR: begin
                if (aluReq.wide) begin
                    res17 = {1'b0, carryIn, opA[15:1]};
                end else begin
                    res17 = {9'h000, carryIn, opA[7:1]};
                end
            end
        endcase
        signA = aluReq.wide ? opA[15] : opA[7];
        signB = aluReq.wide ? opB[15] : opB[7];
        signR = aluReq.wide ? res17[15] : res17[7];
        statusAlu[`CRM_FLAG_NEG] = signR;
        if (aluReq.wide) begin
            statusAlu[`CRM_FLAG_ZERO] = (res17[15:0] == 16'h0000);
        end else begin
            statusAlu[`CRM_FLAG_ZERO] = (res17[7:0] == 8'h00);
        end
        if (aluReq.op == crm_pkg::OP_SHL) begin
            statusAlu[`CRM_FLAG_CARRY] = signA;
        end else if (aluReq.op == crm_pkg::OP_SHR) begin
            statusAlu[`CRM_FLAG_CARRY] = opA[0];
        end else begin
            statusAlu[`CRM_FLAG_CARRY] = aluReq.wide ? res17[16] : res17[8];
            statusAlu[`CRM_FLAG_HALF] = half5[4];
            if (aluReq.op == crm_pkg::OP_ADD || aluReq.op == crm_pkg::OP_ADDC) begin
                statusAlu[`CRM_FLAG_OVFL] = (signA == signB) && (signR != signA);
            end else begin
                statusAlu[`CRM_FLAG_OVFL] = (signA != signB) && (signR != signA);
            end
        end
        if (aluReq.wide) begin
            accum_d = res17[15:0];
        end else begin
            accum_d = {accum_q[15:8], res17[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter: bus, then load, then increment.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            progCnt_q <= `CRM_PROG_CNT_RST;
        end else if (busWrHit(`CRM_IDX_PROG_CNT)) begin
            progCnt_q <= regWdata;
        end else if (loadHit(`CRM_IDX_PROG_CNT)) begin
            progCnt_q <= loadReq.data;
        end else if (countUp) begin
            progCnt_q <= progCnt_q + 16'h0001;
        end
    end

    // Accumulator pair.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accum_q <= `CRM_REG_RST;
            tempAcc_q <= `CRM_REG_RST;
        end else begin
            if (busWrHit(`CRM_IDX_ACCUM)) begin
                accum_q <= regWdata;
            end else if (loadHit(`CRM_IDX_ACCUM)) begin
                accum_q <= loadReq.data;
            end else if (aluTake) begin
                accum_q <= accum_d;
            end
            if (busWrHit(`CRM_IDX_TEMP_ACC)) begin
                tempAcc_q <= regWdata;
            end else if (loadHit(`CRM_IDX_TEMP_ACC)) begin
                tempAcc_q <= loadReq.data;
            end
        end
    end

    // Address pointers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            indexReg_q <= `CRM_REG_RST;
            extraPtr_q <= `CRM_REG_RST;
            stackPtr_q <= `CRM_REG_RST;
        end else begin
            if (busWrHit(`CRM_IDX_INDEX)) begin
                indexReg_q <= regWdata;
            end else if (loadHit(`CRM_IDX_INDEX)) begin
                indexReg_q <= loadReq.data;
            end
            if (busWrHit(`CRM_IDX_EXTRA)) begin
                extraPtr_q <= regWdata;
            end else if (loadHit(`CRM_IDX_EXTRA)) begin
                extraPtr_q <= loadReq.data;
            end
            if (busWrHit(`CRM_IDX_STACK)) begin
                stackPtr_q <= regWdata;
            end else if (loadHit(`CRM_IDX_STACK)) begin
                stackPtr_q <= loadReq.data;
            end
        end
    end

    // Program status; reset leaves interrupts disabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= `CRM_STATUS_RST;
        end else if (busWrHit(`CRM_IDX_STATUS)) begin
            status_q <= regWdata;
        end else if (loadHit(`CRM_IDX_STATUS)) begin
            status_q <= loadReq.data;
        end else if (aluTake) begin
            status_q <= statusAlu;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt admission against the enable bit and the level field.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqAccept_q <= 1'b0;
        end else begin
            irqAccept_q <= irqReq && status_q[`CRM_FLAG_IEN]
                && (status_q[`CRM_IL_MSB:`CRM_IL_LSB] != `CRM_IL_NONE)
                && (irqLevel < status_q[`CRM_IL_MSB:`CRM_IL_LSB]);
        end
    end

    // Area decode of a memory address and the base of the active bank.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            areaIo_q <= 1'b0;
            areaData_q <= 1'b0;
            areaProg_q <= 1'b0;
            gprBase_q <= `CRM_GPR_AREA;
        end else begin
            areaIo_q <= (memAddr < `CRM_IO_TOP);
            areaData_q <= (memAddr >= `CRM_IO_TOP) && (memAddr < PROG_BASE);
            areaProg_q <= (memAddr >= PROG_BASE);
            gprBase_q <= `CRM_GPR_AREA + {9'h000, bank, 3'b000};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data of the dedicated registers; zero outside the answer cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ddRdata_q <= '0;
            rdGpr_q <= 1'b0;
        end else begin
            rdGpr_q <= regRd && gprHit;
            ddRdata_q <= '0;
            if (regRd && !gprHit) begin
                unique case (regAddr)
                    `CRM_IDX_PROG_CNT: ddRdata_q <= progCnt_q;
                    `CRM_IDX_ACCUM: ddRdata_q <= accum_q;
                    `CRM_IDX_TEMP_ACC: ddRdata_q <= tempAcc_q;
                    `CRM_IDX_INDEX: ddRdata_q <= indexReg_q;
                    `CRM_IDX_EXTRA: ddRdata_q <= extraPtr_q;
                    `CRM_IDX_STACK: ddRdata_q <= stackPtr_q;
                    `CRM_IDX_STATUS: ddRdata_q <= status_q;
                    default: ddRdata_q <= '0;
                endcase
            end
        end
    end

    // The bank pointer picks which eight bytes the upper indices reach.
    crm_gpr_mem u_gpr_mem (
        .clk(clk),
        .rst(rst),
        .addr({bank, regAddr[2:0]}),
        .wrData(regWdata[7:0]),
        .wrEn(regWr && gprHit),
        .rdEn(regRd && gprHit),
        .rdData(memRdata)
    );

    assign regRdata = rdGpr_q ? {8'h00, memRdata} : ddRdata_q;
    assign regsOut = '{progCnt_q, accum_q, tempAcc_q, indexReg_q, extraPtr_q,
                       stackPtr_q, status_q};
    assign gprBase = gprBase_q;
    assign irqAccept = irqAccept_q;
    assign areaIo = areaIo_q;
    assign areaData = areaData_q;
    assign areaProg = areaProg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_COUNT_STEP: assert property (
        countUp && !busWrHit(`CRM_IDX_PROG_CNT) && !loadHit(`CRM_IDX_PROG_CNT)
        |=> progCnt_q == $past(progCnt_q) + 16'h0001)
        else $error("Program counter did not step by one.");

    AST_BYTE_KEEPS_HIGH: assert property (
        aluTake && !aluReq.wide |=> accum_q[15:8] == $past(accum_q[15:8]))
        else $error("Byte operation changed the accumulator high byte.");

    AST_TEMP_HELD: assert property (
        aluTake && !busWrHit(`CRM_IDX_TEMP_ACC) && !loadHit(`CRM_IDX_TEMP_ACC)
        |=> $stable(tempAcc_q))
        else $error("Arithmetic changed the temporary accumulator.");

    AST_ZERO_NEG: assert property (
        aluTake && !aluReq.wide && !busWrHit(`CRM_IDX_STATUS) && !loadHit(`CRM_IDX_STATUS)
        |=> status_q[`CRM_FLAG_ZERO] == (accum_q[7:0] == 8'h00)
            && status_q[`CRM_FLAG_NEG] == accum_q[7])
        else $error("Zero or negative flag disagrees with the result.");

    AST_ADD_CARRY: assert property (
        aluTake && !aluReq.wide && aluReq.op == crm_pkg::OP_ADD
        && !busWrHit(`CRM_IDX_STATUS) && !loadHit(`CRM_IDX_STATUS)
        |=> status_q[`CRM_FLAG_CARRY]
            == ({1'b0, $past(accum_q[7:0])} + {1'b0, $past(tempAcc_q[7:0])} > 9'h0FF))
        else $error("Carry flag wrong after byte addition.");

    AST_SHIFT_CARRY: assert property (
        aluTake && !aluReq.wide && aluReq.op == crm_pkg::OP_SHL
        && !busWrHit(`CRM_IDX_STATUS) && !loadHit(`CRM_IDX_STATUS)
        |=> status_q[`CRM_FLAG_CARRY] == $past(accum_q[7]))
        else $error("Shift did not load carry with the bit shifted out.");

    AST_IRQ_NEEDS_ENABLE: assert property (
        irqAccept_q |-> $past(status_q[`CRM_FLAG_IEN]) && $past(irqReq))
        else $error("Interrupt admitted while disabled.");

    AST_LEVEL_THREE_BLOCKS: assert property (
        status_q[`CRM_IL_MSB:`CRM_IL_LSB] == `CRM_IL_NONE |=> !irqAccept_q)
        else $error("Interrupt admitted with level field at three.");

    AST_IO_AREA: assert property (
        memAddr < `CRM_IO_TOP |=> areaIo_q && !areaData_q && !areaProg_q)
        else $error("Low address not decoded as I/O area.");

    AST_READ_ONE_CYCLE: assert property (
        !regRd |=> regRdata == 16'h0000)
        else $error("Read data present without a read.");

    COV_ADD_CARRY: cover property (aluTake && aluReq.op == crm_pkg::OP_ADD
        ##1 status_q[`CRM_FLAG_CARRY]);
    COV_IRQ_TAKEN: cover property (irqReq ##1 irqAccept_q);
    COV_GPR_READ: cover property (regRd && gprHit ##1 rdGpr_q);
    COV_SHIFT_RIGHT: cover property (aluTake && aluReq.op == crm_pkg::OP_SHR);

endmodule : crm_core_regs

// file: rtl/crm_gpr_mem.sv
`timescale 1ns/1ns
`include "crm_regs.svh"

module crm_gpr_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`CRM_MEM_AW-1:0] addr,
    input wire logic [`CRM_MEM_DW-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [`CRM_MEM_DW-1:0] rdData
);

    logic [`CRM_MEM_DW-1:0] mem [0:(1<<`CRM_MEM_AW)-1];
    logic [`CRM_MEM_DW-1:0] rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // The array has no reset, so bank contents are unknown until written.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end

    // Read data are zero in every cycle that does not follow a read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (rdEn) begin
            rdData_q <= mem[addr];
        end else begin
            rdData_q <= '0;
        end
    end

    assign rdData = rdData_q;

endmodule : crm_gpr_mem

// file: rtl/crm_pkg.sv
package crm_pkg;

    // Operations the datapath may ask of the accumulator pair.
    typedef enum logic [2:0] {
        OP_ADD,
        OP_ADDC,
        OP_SUB,
        OP_SUBC,
        OP_SHL,
        OP_SHR
    } crm_alu_op_t;

    // One arithmetic request; the result replaces the accumulator, or only its low byte when wide is clear.
    typedef struct packed {
        logic valid;
        logic wide;
        crm_alu_op_t op;
    } crm_alu_req_t;

    // A direct load of one dedicated register by the datapath.
    typedef struct packed {
        logic valid;
        logic [3:0] sel;
        logic [15:0] data;
    } crm_load_t;

    // The dedicated registers as one bundle.
    typedef struct packed {
        logic [15:0] progCnt;
        logic [15:0] accum;
        logic [15:0] tempAcc;
        logic [15:0] indexReg;
        logic [15:0] extraPtr;
        logic [15:0] stackPtr;
        logic [15:0] progStatus;
    } crm_regs_t;

endpackage : crm_pkg

// file: rtl/crm_regs.svh
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH

// Word indices on the register port.
`define CRM_IDX_PROG_CNT 4'h0
`define CRM_IDX_ACCUM 4'h1
`define CRM_IDX_TEMP_ACC 4'h2
`define CRM_IDX_INDEX 4'h3
`define CRM_IDX_EXTRA 4'h4
`define CRM_IDX_STACK 4'h5
`define CRM_IDX_STATUS 4'h6
// Indices 8 to 15 reach the eight general-purpose bytes of the active bank.
`define CRM_IDX_GPR_BIT 3

// Field positions inside the program status word.
`define CRM_FLAG_CARRY 0
`define CRM_FLAG_OVFL 1
`define CRM_FLAG_ZERO 2
`define CRM_FLAG_NEG 3
`define CRM_IL_LSB 4
`define CRM_IL_MSB 5
`define CRM_FLAG_IEN 6
`define CRM_FLAG_HALF 7
`define CRM_BANK_LSB 8
`define CRM_BANK_MSB 11
`define CRM_IL_NONE 2'h3

// Reset values.
`define CRM_PROG_CNT_RST 16'h0000
`define CRM_STATUS_RST 16'h0000
`define CRM_REG_RST 16'h0000

// Address map of the 64 Kbyte space.
`define CRM_IO_TOP 16'h0080
`define CRM_PROG_BASE 16'h8000
`define CRM_GPR_AREA 16'h0100

// General-purpose register memory: 16 banks of 8 bytes.
`define CRM_MEM_AW 7
`define CRM_MEM_DW 8

`endif

// file: test/cpu_register_model_tb_top.sv
`timescale 1ns/1ns
`include "crm_regs.svh"

module cpu_register_model_tb_top;

    logic clk;
    logic rst;
    logic [3:0] regAddr;
    logic [15:0] regWdata;
    logic regWr;
    logic regRd;
    logic [15:0] regRdata;
    crm_pkg::crm_alu_req_t aluReq;
    crm_pkg::crm_load_t loadReq;
    logic countUp;
    logic [15:0] memAddr;
    logic irqReq;
    logic [1:0] irqLevel;
    crm_pkg::crm_regs_t regsOut;
    logic [15:0] gprBase;
    logic irqAccept;
    logic areaIo;
    logic areaData;
    logic areaProg;
    int n_fail = 0;
    int total_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    crm_core_regs i_crm_core_regs (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .aluReq(aluReq), .loadReq(loadReq), .countUp(countUp), .memAddr(memAddr),
        .irqReq(irqReq), .irqLevel(irqLevel), .regsOut(regsOut), .gprBase(gprBase),
        .irqAccept(irqAccept), .areaIo(areaIo), .areaData(areaData), .areaProg(areaProg));

    crm_datapath_model i_crm_datapath_model (.clk(clk), .aluReq(aluReq), .loadReq(loadReq),
        .countUp(countUp), .memAddr(memAddr), .irqReq(irqReq), .irqLevel(irqLevel));

    // Free-running 4 ns clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus write; the idle cycle after it keeps a strobe from being driven twice at one edge.
    task automatic wr(input logic [3:0] idx, input logic [15:0] data);
        regWr <= 1'b1;
        regAddr <= idx;
        regWdata <= data;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
    task automatic rdChk(input logic [3:0] idx, input logic [15:0] exp);
        regRd <= 1'b1;
        regAddr <= idx;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
        @(posedge clk);
    endtask : rdChk

    // Loads operands and carry, runs one operation, then reads result and flags back.
    task automatic aluCase(input crm_pkg::crm_alu_op_t op, input logic wide,
        input logic [15:0] a, input logic [15:0] b, input logic cin,
        input logic [15:0] expA, input logic [7:0] expF);
        wr(`CRM_IDX_ACCUM, a);
        wr(`CRM_IDX_TEMP_ACC, b);
        wr(`CRM_IDX_STATUS, {15'h0000, cin});
        i_crm_datapath_model.alu(op, wide);
        rdChk(`CRM_IDX_ACCUM, expA);
        rdChk(`CRM_IDX_STATUS, {8'h00, expF});
    endtask : aluCase

    task automatic areaChk(input logic [15:0] addr, input logic [2:0] exp);
        i_crm_datapath_model.probe(addr);
        @(posedge clk);
        @(negedge clk);
        chk({13'h0000, areaIo, areaData, areaProg}, {13'h0000, exp});
        @(posedge clk);
    endtask : areaChk

    ////////////////////////////////////////////////////////////////////////////////
    // The whole run needs well under a thousand cycles; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) rdChk(4'(i), 16'h0000);
        chk(gprBase, 16'h0100);
        chk({15'h0000, irqAccept}, 16'h0000);
        // Distinct values in every register expose a wrong decode.
        for (int i = 0; i < 7; i++) wr(4'(i), 16'hA5C0 | 16'(i));
        for (int i = 0; i < 7; i++) rdChk(4'(i), 16'hA5C0 | 16'(i));
        chk(regsOut.stackPtr, 16'hA5C5);
        chk(regsOut.progCnt, 16'hA5C0);
        chk(regsOut.accum, 16'hA5C1);
        chk(regsOut.tempAcc, 16'hA5C2);
        chk(regsOut.indexReg, 16'hA5C3);
        chk(regsOut.extraPtr, 16'hA5C4);
        chk(regsOut.progStatus, 16'hA5C6);
        wr(4'h7, 16'hFFFF);
        rdChk(4'h7, 16'h0000);
        // Banks: the pointer selects which eight bytes the general indices reach.
        wr(`CRM_IDX_STATUS, 16'h0300);
        wr(4'h8, 16'h12AB);
        wr(4'hF, 16'h00CD);
        chk(gprBase, 16'h0118);
        wr(`CRM_IDX_STATUS, 16'h0F00);
        wr(4'h8, 16'h0011);
        rdChk(4'h8, 16'h0011);
        chk(gprBase, 16'h0178);
        wr(`CRM_IDX_STATUS, 16'h0300);
        rdChk(4'h8, 16'h00AB);
        rdChk(4'hF, 16'h00CD);
        // Arithmetic and shifts; flags byte is H,IEN,IL,N,Z,V,C from the top bit down.
        aluCase(crm_pkg::OP_ADD, 1'b0, 16'h12FF, 16'h0001, 1'b0, 16'h1200, 8'h85);
        aluCase(crm_pkg::OP_ADD, 1'b0, 16'h0050, 16'h0050, 1'b0, 16'h00A0, 8'h0A);
        aluCase(crm_pkg::OP_SUB, 1'b0, 16'h0010, 16'h0001, 1'b0, 16'h000F, 8'h80);
        aluCase(crm_pkg::OP_SUB, 1'b0, 16'h0000, 16'h0001, 1'b0, 16'h00FF, 8'h89);
        aluCase(crm_pkg::OP_ADDC, 1'b0, 16'h0001, 16'h0001, 1'b1, 16'h0003, 8'h00);
        aluCase(crm_pkg::OP_SUBC, 1'b0, 16'h0005, 16'h0001, 1'b1, 16'h0003, 8'h00);
        aluCase(crm_pkg::OP_SHL, 1'b0, 16'h0081, 16'h0000, 1'b0, 16'h0002, 8'h01);
        aluCase(crm_pkg::OP_SHR, 1'b0, 16'h0001, 16'h0000, 1'b1, 16'h0080, 8'h09);
        aluCase(crm_pkg::OP_SHL, 1'b1, 16'h8001, 16'h0000, 1'b1, 16'h0003, 8'h01);
        aluCase(crm_pkg::OP_SHR, 1'b1, 16'h0002, 16'h0000, 1'b1, 16'h8001, 8'h08);
        aluCase(crm_pkg::OP_ADD, 1'b1, 16'hFFFF, 16'h0001, 1'b0, 16'h0000, 8'h85);
        aluCase(crm_pkg::OP_SUB, 1'b1, 16'h8000, 16'h0001, 1'b0, 16'h7FFF, 8'h82);
        // Fetch address wraps at the top of the 64 Kbyte space.
        i_crm_datapath_model.load(`CRM_IDX_PROG_CNT, 16'hFFFE);
        i_crm_datapath_model.count(2);
        @(negedge clk);
        chk(regsOut.progCnt, 16'h0000);
        @(posedge clk);
        i_crm_datapath_model.load(`CRM_IDX_EXTRA, 16'h3C3C);
        rdChk(`CRM_IDX_EXTRA, 16'h3C3C);
        // A bus write wins over a datapath load of the same register.
        fork
            wr(`CRM_IDX_INDEX, 16'h1111);
            i_crm_datapath_model.load(`CRM_IDX_INDEX, 16'h2222);
        join
        rdChk(`CRM_IDX_INDEX, 16'h1111);
        // Every enable, field value and request level.
        for (int e = 0; e < 2; e++) begin
            for (int f = 0; f < 4; f++) begin
                for (int v = 0; v < 4; v++) begin
                    wr(`CRM_IDX_STATUS, {9'h000, 1'(e), 2'(f), 4'h0});
                    i_crm_datapath_model.irq(1'b1, 2'(v));
                    @(posedge clk);
                    @(negedge clk);
                    chk({15'h0000, irqAccept}, 16'((e == 1) && (f != 3) && (v < f)));
                    @(posedge clk);
                end
            end
        end
        i_crm_datapath_model.irq(1'b0, 2'h0);
        wr(`CRM_IDX_STATUS, 16'h0060);
        @(negedge clk);
        chk({15'h0000, irqAccept}, 16'h0000);
        @(posedge clk);
        // Area decode at each boundary of the map.
        areaChk(16'h0000, 3'b100);
        areaChk(16'h007C, 3'b100);
        areaChk(16'h0080, 3'b010);
        areaChk(16'h7FFF, 3'b010);
        areaChk(16'h8000, 3'b001);
        areaChk(16'hFFFF, 3'b001);
        end_sim();
    end

endmodule : cpu_register_model_tb_top

// file: test/crm_datapath_model.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Behavioural stand-in for the instruction datapath on the far side of the registers.
// Every request is raised right after a rising edge; ALU and load requests are held until the edge that takes them, interrupt and address until changed.
module crm_datapath_model (
    input wire logic clk,
    output crm_pkg::crm_alu_req_t aluReq,
    output crm_pkg::crm_load_t loadReq,
    output logic countUp,
    output logic [15:0] memAddr,
    output logic irqReq,
    output logic [1:0] irqLevel
);

    // Everything is quiet at time zero so the first edge after reset sees no request.
    initial begin
        aluReq = '0;
        loadReq = '0;
        countUp = 1'b0;
        memAddr = 16'h0000;
        irqReq = 1'b0;
        irqLevel = 2'h0;
    end

    // One arithmetic request, taken at the next rising edge.
    task automatic alu(input crm_pkg::crm_alu_op_t op, input logic wide);
        aluReq <= '{valid: 1'b1, wide: wide, op: op};
        @(posedge clk);
        aluReq <= '0;
    endtask : alu

    // One direct load of a dedicated register.
    task automatic load(input logic [3:0] sel, input logic [15:0] data);
        loadReq <= '{valid: 1'b1, sel: sel, data: data};
        @(posedge clk);
        loadReq <= '0;
    endtask : load

    // Step the fetch address for a number of cycles.
    task automatic count(input int n);
        countUp <= 1'b1;
        repeat (n) @(posedge clk);
        countUp <= 1'b0;
    endtask : count

    // Interrupt request is a level, so it simply stays until changed.
    task automatic irq(input logic req, input logic [1:0] lvl);
        irqReq <= req;
        irqLevel <= lvl;
    endtask : irq

    // The caller presents addresses from the I/O, data and program areas, at or near the ends of each.
    task automatic probe(input logic [15:0] addr);
        memAddr <= addr;
    endtask : probe

endmodule : crm_datapath_model
